// File: rtl/vout_cfg_regs.sv
// Output-voltage configuration registers and over-voltage fault response.
`timescale 1ns/100ps
// How it works
// - Margin-high target word at 0x25, strap default.
// - Margin-low target word at 0x26, strap default.
// - Slew rate word at 0x27 steers slewing.
// - Load-line slope word stored at 0x28.
// - Duty limit percentage word at 0x32.
// - Switching frequency kHz word at 0x33.
// - Group identifier in bits 11:8, default zero.
// - Rail count bits 7:4, zero means sixteen.
// - Rail position bits 3:0, address strap default.
// - Sense gain word at 0x38 stored, not applied.
// - Sense offset word at 0x39 added to readings.
// - Over-voltage limit at 0x40 compared to output.
// - Any fault drives alert low, sets flag.
// - Code 00 ignores; code 10 disables, retries.
// - Code 01 waits delay, then disables if still present.
// - Code 11 disables only while fault persists.
// - Retry count; zero stays off until cleared.
// - Voltage values scaled by five-bit exponent.
// - Command 0x03 clears faults, releases latched off.
module vout_cfg_regs #(
	parameter int DELAY_UNIT_CYCLES = vout_cfg_pkg::DELAY_UNIT_CYC
) (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Straps, caught after reset release.
	input  wire logic [15:0] voltage_select_strap,
	input  wire logic [6:0]  bus_address_strap,
	// Command port from the link engine.
	input  wire logic        cmd_write,
	input  wire logic        cmd_read,
	input  wire logic        cmd_send,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic      [15:0] read_data,
	output logic             read_valid,
	// Measurement and control.
	input  wire logic [15:0] output_voltage,
	input  wire logic [15:0] output_current_raw,
	output logic      [15:0] output_current_reading,
	output logic      [15:0] slew_target_rate,
	output logic      [4:0]  rails_in_group,
	output logic      [3:0]  phase_slot,
	output logic             output_enable,
	output logic             ov_fault_flag,
	output logic             alert_line_n
);
	import vout_cfg_pkg::*;

	if (DELAY_UNIT_CYCLES < 1) begin
		$error("delay unit must be at least one cycle");
	end

	logic [15:0] margin_high_target_reg;
	logic [15:0] margin_low_target_reg;
	logic [15:0] output_slew_rate_reg;
	logic [15:0] load_line_slope_reg;
	logic [15:0] duty_cycle_limit_reg;
	logic [15:0] switching_rate_reg;
	logic [15:0] phase_group_position_reg;
	logic [15:0] current_sense_gain_reg;
	logic [15:0] current_sense_offset_reg;
	logic [15:0] overvoltage_limit_reg;
	logic [7:0]  overvoltage_action_reg;
	logic [7:0]  vout_mode_reg;
	logic [7:0]  low_byte_reg;
	logic        low_held_reg;
	logic        strap_done_reg;
	logic        wr_word;
	logic        wr_byte;
	logic [15:0] wr_value;

	// ---------------------------------------------------------------------
	// Write assembly
	// ---------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_byte_reg <= 8'h00;
			low_held_reg <= 1'b0;
		end else if (cmd_write && byte_valid) begin
			low_byte_reg <= byte_data;
			low_held_reg <= !low_held_reg;
		end else if (!cmd_write) begin
			low_held_reg <= 1'b0;
		end
	end
	assign wr_word  = cmd_write && byte_valid && low_held_reg;
	assign wr_byte  = cmd_write && byte_valid && !low_held_reg;
	assign wr_value = {byte_data, low_byte_reg};

	// ---------------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			margin_high_target_reg   <= RST_WORD;
			margin_low_target_reg    <= RST_WORD;
			output_slew_rate_reg     <= RST_WORD;
			load_line_slope_reg      <= RST_WORD;
			duty_cycle_limit_reg     <= RST_WORD;
			switching_rate_reg       <= RST_WORD;
			phase_group_position_reg <= RST_WORD;
			current_sense_gain_reg   <= RST_WORD;
			current_sense_offset_reg <= RST_WORD;
			overvoltage_limit_reg    <= RST_WORD;
			overvoltage_action_reg   <= RST_ACTION;
			vout_mode_reg            <= RST_MODE;
			strap_done_reg           <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg           <= 1'b1;
			margin_high_target_reg   <= voltage_select_strap;
			margin_low_target_reg    <= voltage_select_strap;
			overvoltage_limit_reg    <= voltage_select_strap;
			phase_group_position_reg <= {8'h00, 4'h0, bus_address_strap[3:0]};
		end else if (wr_byte && cmd_code == CMD_OV_ACTION) begin
			overvoltage_action_reg <= byte_data;
		end else if (wr_byte && cmd_code == CMD_VOUT_MODE) begin
			vout_mode_reg <= byte_data;
		end else if (wr_word) begin
			unique case (cmd_code)
				CMD_MARGIN_HIGH:  margin_high_target_reg   <= wr_value;
				CMD_MARGIN_LOW:   margin_low_target_reg    <= wr_value;
				CMD_SLEW_RATE:    output_slew_rate_reg     <= wr_value;
				CMD_LOAD_LINE:    load_line_slope_reg      <= wr_value;
				CMD_DUTY_LIMIT:   duty_cycle_limit_reg     <= wr_value;
				CMD_SWITCH_RATE:  switching_rate_reg       <= wr_value;
				CMD_PHASE_GROUP:  phase_group_position_reg <= {4'h0, wr_value[11:0]};
				CMD_SENSE_GAIN:   current_sense_gain_reg   <= wr_value;
				CMD_SENSE_OFFSET: current_sense_offset_reg <= wr_value;
				CMD_OV_LIMIT:     overvoltage_limit_reg    <= wr_value;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			read_data  <= 16'h0000;
			read_valid <= 1'b0;
		end else begin
			read_valid <= cmd_read;
			if (cmd_read) begin
				unique case (cmd_code)
					CMD_VOUT_MODE:    read_data <= {8'h00, vout_mode_reg};
					CMD_MARGIN_HIGH:  read_data <= margin_high_target_reg;
					CMD_MARGIN_LOW:   read_data <= margin_low_target_reg;
					CMD_SLEW_RATE:    read_data <= output_slew_rate_reg;
					CMD_LOAD_LINE:    read_data <= load_line_slope_reg;
					CMD_DUTY_LIMIT:   read_data <= duty_cycle_limit_reg;
					CMD_SWITCH_RATE:  read_data <= switching_rate_reg;
					CMD_PHASE_GROUP:  read_data <= phase_group_position_reg;
					CMD_SENSE_GAIN:   read_data <= current_sense_gain_reg;
					CMD_SENSE_OFFSET: read_data <= current_sense_offset_reg;
					CMD_OV_LIMIT:     read_data <= overvoltage_limit_reg;
					CMD_OV_ACTION:    read_data <= {8'h00, overvoltage_action_reg};
					default:          read_data <= 16'h0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------------
	// Derived control outputs
	// ---------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			output_current_reading <= 16'h0000;
			slew_target_rate       <= 16'h0000;
			rails_in_group         <= RAILS_ZERO_AS;
			phase_slot             <= 4'h0;
		end else begin
			output_current_reading <= output_current_raw + current_sense_offset_reg;
			slew_target_rate       <= output_slew_rate_reg;
			if (phase_group_position_reg[RAIL_COUNT_LSB +: 4] == 4'h0) begin
				rails_in_group <= RAILS_ZERO_AS;
			end else begin
				rails_in_group <= {1'b0, phase_group_position_reg[RAIL_COUNT_LSB +: 4]};
			end
			phase_slot <= phase_group_position_reg[RAIL_POS_LSB +: 4];
		end
	end

	// ---------------------------------------------------------------------
	// Over-voltage response
	// ---------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN,
		ST_DEFER,
		ST_OFF,
		ST_WAIT,
		ST_HELD,
		ST_LATCHED
	} ov_state_e;
	ov_state_e   ov_state_reg;
	logic        ov_now;
	logic        wipe;
	logic [1:0]  resp;
	logic [2:0]  retries;
	logic [2:0]  delay_n;
	logic [2:0]  tries_reg;
	logic [31:0] timer_reg;
	logic [31:0] wait_cycles;

	// Comparison is on raw mantissas; both share the exponent.
	// No fault is seen before the straps have loaded the limit.
	assign ov_now      = strap_done_reg &&
		(output_voltage > overvoltage_limit_reg);
	assign wipe        = cmd_send && cmd_code == CMD_FAULT_FLAG_WIPE;
	assign resp        = overvoltage_action_reg[RESP_LSB +: 2];
	assign retries     = overvoltage_action_reg[RETRY_LSB +: 3];
	assign delay_n     = overvoltage_action_reg[DELAY_LSB +: 3];
	assign wait_cycles = 32'(delay_n) * 32'(DELAY_UNIT_CYCLES);

	// A fault in the same cycle as a clear wins, so a live fault keeps the flag.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ov_fault_flag <= 1'b0;
			alert_line_n  <= 1'b1;
		end else if (ov_now) begin
			ov_fault_flag <= 1'b1;
			alert_line_n  <= 1'b0;
		end else if (wipe) begin
			ov_fault_flag <= 1'b0;
			alert_line_n  <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ov_state_reg  <= ST_RUN;
			output_enable <= 1'b1;
			timer_reg     <= 32'h0;
			tries_reg     <= 3'h0;
		end else begin
			unique case (ov_state_reg)
				ST_RUN: begin
					output_enable <= 1'b1;
					tries_reg     <= 3'h0;
					timer_reg     <= wait_cycles;
					if (ov_now && resp == RESP_DEFER) begin
						ov_state_reg <= ST_DEFER;
					end else if (ov_now && resp == RESP_DISABLE) begin
						ov_state_reg  <= ST_OFF;
						output_enable <= 1'b0;
					end else if (ov_now && resp == RESP_WHILE) begin
						ov_state_reg  <= ST_HELD;
						output_enable <= 1'b0;
					end
				end
				ST_DEFER: begin
					if (!ov_now) begin
						ov_state_reg <= ST_RUN;
					end else if (timer_reg == 32'h0) begin
						ov_state_reg  <= ST_OFF;
						output_enable <= 1'b0;
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				ST_OFF: begin
					timer_reg <= wait_cycles;
					// Setting zero, or every try spent, keeps the output off until a clear.
					if (retries == RETRY_NONE ||
						(retries != RETRY_FOREVER && tries_reg == retries)) begin
						ov_state_reg <= ST_LATCHED;
					end else begin
						ov_state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (timer_reg == 32'h0) begin
						tries_reg     <= tries_reg + 3'h1;
						output_enable <= !ov_now;
						ov_state_reg  <= ov_now ? ST_OFF : ST_RUN;
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				ST_HELD: begin
					if (!ov_now) begin
						ov_state_reg  <= ST_RUN;
						output_enable <= 1'b1;
					end
				end
				ST_LATCHED: begin
					output_enable <= 1'b0;
					if (wipe) begin
						ov_state_reg <= ST_RUN;
					end
				end
				default: ov_state_reg <= ST_RUN;
			endcase
		end
	end
endmodule

// File: shared/vout_cfg_pkg.sv
// Command codes, field positions, reset values and timing counts of the configuration block.
package vout_cfg_pkg;
	// -------------------------------------------------------------------------
	// Command codes
	// -------------------------------------------------------------------------
	localparam logic [7:0] CMD_FAULT_FLAG_WIPE   = 8'h03;
	localparam logic [7:0] CMD_VOUT_MODE         = 8'h20;
	localparam logic [7:0] CMD_MARGIN_HIGH       = 8'h25;
	localparam logic [7:0] CMD_MARGIN_LOW        = 8'h26;
	localparam logic [7:0] CMD_SLEW_RATE         = 8'h27;
	localparam logic [7:0] CMD_LOAD_LINE         = 8'h28;
	localparam logic [7:0] CMD_DUTY_LIMIT        = 8'h32;
	localparam logic [7:0] CMD_SWITCH_RATE       = 8'h33;
	localparam logic [7:0] CMD_PHASE_GROUP       = 8'h37;
	localparam logic [7:0] CMD_SENSE_GAIN        = 8'h38;
	localparam logic [7:0] CMD_SENSE_OFFSET      = 8'h39;
	localparam logic [7:0] CMD_OV_LIMIT          = 8'h40;
	localparam logic [7:0] CMD_OV_ACTION         = 8'h41;
	// -------------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------------
	localparam int GROUP_ID_LSB    = 8;
	localparam int RAIL_COUNT_LSB  = 4;
	localparam int RAIL_POS_LSB    = 0;
	localparam int RESP_LSB        = 6;
	localparam int RETRY_LSB       = 3;
	localparam int DELAY_LSB       = 0;
	localparam int EXP_LSB         = 0;
	// -------------------------------------------------------------------------
	// Response codes and reset values
	// -------------------------------------------------------------------------
	localparam logic [1:0] RESP_IGNORE   = 2'h0;
	localparam logic [1:0] RESP_DEFER    = 2'h1;
	localparam logic [1:0] RESP_DISABLE  = 2'h2;
	localparam logic [1:0] RESP_WHILE    = 2'h3;
	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [4:0] RAILS_ZERO_AS = 5'h10;
	localparam logic [15:0] RST_WORD     = 16'h0000;
	localparam logic [7:0]  RST_ACTION   = 8'h80;
	localparam logic [7:0]  RST_MODE     = 8'h00;
	// -------------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 5;
	localparam int DELAY_UNIT_US   = 10;
	localparam int DELAY_UNIT_CYC  = DELAY_UNIT_US * 1000 / CLK_PERIOD_NS;
endpackage

// File: verif/host_model.sv
// Host-side driver of the command port of the configuration registers.
`timescale 1ns/100ps
module host_model (
	// Clock and read answer.
	input  wire logic        sys_clk,
	input  wire logic [15:0] read_data,
	input  wire logic        read_valid,
	// Command port.
	output logic             cmd_write,
	output logic             cmd_read,
	output logic             cmd_send,
	output logic      [7:0]  cmd_code,
	output logic             byte_valid,
	output logic      [7:0]  byte_data
);
	initial begin
		{cmd_write, cmd_read, cmd_send, byte_valid} = 4'h0;
		cmd_code = 8'hff;
		byte_data = 8'hff;
	end
	// Idle lines show the inverse of the last value, never a stale copy.
	task automatic wr(input logic [7:0] code, input logic [15:0] data, input bit word);
		@(posedge sys_clk);
		#1;
		cmd_write = 1'b1;
		cmd_code = code;
		byte_valid = 1'b1;
		byte_data = data[7:0];
		if (word) begin
			@(posedge sys_clk);
			#1;
			byte_data = data[15:8];
		end
		@(posedge sys_clk);
		#1;
		{cmd_write, byte_valid} = 2'h0;
		cmd_code = ~code;
		byte_data = ~byte_data;
	endtask
	task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
		@(posedge sys_clk);
		#1;
		cmd_read = 1'b1;
		cmd_code = code;
		@(posedge sys_clk);
		#1;
		cmd_read = 1'b0;
		cmd_code = ~code;
		ok = read_valid;
		data = read_data;
	endtask
	task automatic snd(input logic [7:0] code);
		@(posedge sys_clk);
		#1;
		cmd_send = 1'b1;
		cmd_code = code;
		@(posedge sys_clk);
		#1;
		cmd_send = 1'b0;
		cmd_code = ~code;
	endtask
endmodule

// File: verif/vout_cfg_regs_bench.sv
// Self-checking bench for the configuration registers.
`timescale 1ns/100ps
module vout_cfg_regs_bench;
	import vout_cfg_pkg::*;
	localparam int UNIT = 4;
	logic        sys_clk, sys_rst, cmd_write, cmd_read, cmd_send, byte_valid, read_valid;
	logic        output_enable, ov_fault_flag, alert_line_n;
	logic [7:0]  cmd_code, byte_data;
	logic [6:0]  bus_address_strap;
	logic [4:0]  rails_in_group;
	logic [3:0]  phase_slot;
	logic [15:0] voltage_select_strap, output_voltage, output_current_raw, read_data;
	logic [15:0] output_current_reading, slew_target_rate;
	int          err_total, checks_done;
	vout_cfg_regs #(
		.DELAY_UNIT_CYCLES(UNIT)
	) u_vout_cfg_regs (
		.sys_clk                (sys_clk),
		.sys_rst                (sys_rst),
		.voltage_select_strap   (voltage_select_strap),
		.bus_address_strap      (bus_address_strap),
		.cmd_write              (cmd_write),
		.cmd_read               (cmd_read),
		.cmd_send               (cmd_send),
		.cmd_code               (cmd_code),
		.byte_valid             (byte_valid),
		.byte_data              (byte_data),
		.read_data              (read_data),
		.read_valid             (read_valid),
		.output_voltage         (output_voltage),
		.output_current_raw     (output_current_raw),
		.output_current_reading (output_current_reading),
		.slew_target_rate       (slew_target_rate),
		.rails_in_group         (rails_in_group),
		.phase_slot             (phase_slot),
		.output_enable          (output_enable),
		.ov_fault_flag          (ov_fault_flag),
		.alert_line_n           (alert_line_n)
	);
	host_model u_host_model (
		.sys_clk    (sys_clk),
		.read_data  (read_data),
		.read_valid (read_valid),
		.cmd_write  (cmd_write),
		.cmd_read   (cmd_read),
		.cmd_send   (cmd_send),
		.cmd_code   (cmd_code),
		.byte_valid (byte_valid),
		.byte_data  (byte_data)
	);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		logic        ok;
		u_host_model.rd(code, d, ok);
		chk(ok === 1'b1 ? d : 16'hxxxx, exp);
	endtask
	task automatic t_reset;
		rchk(CMD_MARGIN_HIGH, 16'h1000);
		rchk(CMD_MARGIN_LOW, 16'h1000);
		rchk(CMD_OV_LIMIT, 16'h1000);
		rchk(CMD_PHASE_GROUP, 16'h000a);
		rchk(CMD_OV_ACTION, 16'h0080);
		chk(rails_in_group, 16'h0010);
		chk(phase_slot, 16'h000a);
		chk({alert_line_n, ov_fault_flag, output_enable}, 16'h0005);
	endtask
	task automatic t_words;
		logic [7:0] w [7] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h32, 8'h38, 8'h39};
		for (int i = 0; i < 7; i++) u_host_model.wr(w[i], {w[i], ~w[i]}, 1'b1);
		for (int i = 0; i < 7; i++) rchk(w[i], {w[i], ~w[i]});
		u_host_model.wr(CMD_SWITCH_RATE, 16'h0190, 1'b1);
		rchk(CMD_SWITCH_RATE, 16'h0190);
		u_host_model.wr(CMD_VOUT_MODE, 16'h001d, 1'b0);
		rchk(CMD_VOUT_MODE, 16'h001d);
		rchk(8'h50, 16'h0000);
		chk(slew_target_rate, 16'h27d8);
		chk(output_current_reading, 16'h3ac6);
		u_host_model.wr(CMD_OV_LIMIT, 16'h0c00, 1'b1);
		rchk(CMD_OV_LIMIT, 16'h0c00);
		output_voltage = 16'h0c00;
		cyc(3);
		chk(ov_fault_flag, 16'h0000);
		output_voltage = 16'h0800;
	endtask
	task automatic t_group;
		u_host_model.wr(CMD_PHASE_GROUP, 16'h0b5c, 1'b1);
		rchk(CMD_PHASE_GROUP, 16'h0b5c);
		chk(rails_in_group, 16'h0005);
		chk(phase_slot, 16'h000c);
		u_host_model.wr(CMD_PHASE_GROUP, 16'h0300, 1'b1);
		cyc(1);
		chk(rails_in_group, 16'h0010);
		chk(phase_slot, 16'h0000);
	endtask
	task automatic t_ov;
		logic [7:0] act [4] = '{8'h00, 8'h80, 8'hc0, 8'h43};
		for (int i = 0; i < 4; i++) begin
			u_host_model.wr(CMD_OV_ACTION, {8'h00, act[i]}, 1'b0);
			output_voltage = 16'h1001;
			cyc(3);
			chk(ov_fault_flag, 16'h0001);
			chk(alert_line_n, 16'h0000);
			chk(output_enable, (i == 0 || i == 3));
			u_host_model.snd(CMD_FAULT_FLAG_WIPE);
			cyc(4 * UNIT);
			chk(ov_fault_flag, 16'h0001);
			chk(output_enable, (i == 0));
			output_voltage = 16'h0800;
			cyc(10);
			chk(output_enable, (i == 0 || i == 2));
			u_host_model.snd(CMD_FAULT_FLAG_WIPE);
			cyc(3);
			chk({alert_line_n, ov_fault_flag, output_enable}, 16'h0005);
		end
	endtask
	task automatic t_retry;
		u_host_model.wr(CMD_OV_ACTION, 16'h0089, 1'b0);
		output_voltage = 16'h1001;
		cyc(3);
		chk(output_enable, 16'h0000);
		output_voltage = 16'h0800;
		cyc(2 * UNIT);
		chk(output_enable, 16'h0001);
		u_host_model.snd(CMD_FAULT_FLAG_WIPE);
		output_voltage = 16'h1001;
		cyc(4 * UNIT);
		chk(output_enable, 16'h0000);
		output_voltage = 16'h0800;
		cyc(4 * UNIT);
		chk(output_enable, 16'h0000);
		u_host_model.snd(CMD_FAULT_FLAG_WIPE);
		cyc(3);
		chk({alert_line_n, ov_fault_flag, output_enable}, 16'h0005);
		u_host_model.wr(CMD_OV_ACTION, 16'h00b9, 1'b0);
		output_voltage = 16'h1001;
		cyc(10 * UNIT);
		chk(output_enable, 16'h0000);
		output_voltage = 16'h0800;
		cyc(3 * UNIT);
		chk(output_enable, 16'h0001);
		chk(ov_fault_flag, 16'h0001);
		u_host_model.snd(CMD_FAULT_FLAG_WIPE);
		cyc(3);
		chk({alert_line_n, ov_fault_flag, output_enable}, 16'h0005);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		{sys_rst, err_total, checks_done} = {1'b1, 64'd0};
		{output_voltage, output_current_raw, voltage_select_strap} = 48'h0800_0100_1000;
		bus_address_strap = 7'h5a;
		repeat (10) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		cyc(2);
		t_reset;
		t_words;
		t_group;
		t_ov;
		t_retry;
		end_of_test;
	end
	initial begin
		#200000;
		err_total++;
		end_of_test;
	end
endmodule

// File: verif/vout_cfg_regs_sva.sv
// Concurrent checks on the ports of the configuration registers.
`timescale 1ns/100ps
module vout_cfg_regs_sva (
	// Clock, reset and commands.
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        cmd_read,
	input wire logic        cmd_send,
	input wire logic [7:0]  cmd_code,
	// Answers and status.
	input wire logic [15:0] read_data,
	input wire logic        read_valid,
	input wire logic [15:0] slew_target_rate,
	input wire logic [4:0]  rails_in_group,
	input wire logic        output_enable,
	input wire logic        ov_fault_flag,
	input wire logic        alert_line_n
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	chk_read_answer: assert property (cmd_read |=> read_valid)
		else $error("read not answered");
	chk_read_quiet: assert property (!cmd_read |=> !read_valid)
		else $error("answer without read");
	chk_slew_readback: assert property (cmd_read && cmd_code == 8'h27
		|=> read_data == slew_target_rate)
		else $error("slew rate mismatch");
	chk_unmapped_zero: assert property (cmd_read && cmd_code == 8'h50
		|=> read_data == 16'h0000)
		else $error("unmapped read not zero");
	chk_rails_range: assert property (rails_in_group != 5'h00
		&& rails_in_group <= 5'h10)
		else $error("rail count out of range");
	chk_alert_tracks: assert property (alert_line_n == !ov_fault_flag)
		else $error("alert and flag disagree");
	chk_flag_sticky: assert property (ov_fault_flag
		&& !(cmd_send && cmd_code == 8'h03) |=> ov_fault_flag)
		else $error("flag dropped without clear");
	chk_clear_cause: assert property ($fell(ov_fault_flag)
		|-> $past(cmd_send) && $past(cmd_code) == 8'h03)
		else $error("flag cleared without command");
	chk_off_needs_fault: assert property ($fell(output_enable) |-> ov_fault_flag)
		else $error("output off without fault");
	cover property (cmd_read ##1 read_valid);
	cover property ($fell(output_enable));
	cover property ($rose(output_enable));
endmodule
bind vout_cfg_regs vout_cfg_regs_sva u_vout_cfg_regs_sva (
	.sys_clk          (sys_clk),
	.sys_rst          (sys_rst),
	.cmd_read         (cmd_read),
	.cmd_send         (cmd_send),
	.cmd_code         (cmd_code),
	.read_data        (read_data),
	.read_valid       (read_valid),
	.slew_target_rate (slew_target_rate),
	.rails_in_group   (rails_in_group),
	.output_enable    (output_enable),
	.ov_fault_flag    (ov_fault_flag),
	.alert_line_n     (alert_line_n)
);
